//--- pur_pkg.sv
package pur_pkg;
  localparam logic [5:0] ADDR_CLOCK4    = 6'h04;
  localparam logic [5:0] ADDR_CONTROL   = 6'h08;
  localparam logic [5:0] ADDR_WATCHDOG  = 6'h09;
  localparam logic [5:0] ADDR_ALARM_MON = 6'h0a;
  localparam logic [5:0] ADDR_ALARM_HR  = 6'h0c;
  localparam logic [5:0] ADDR_SECONDS   = 6'h01;
  localparam logic [5:0] ADDR_FLAGS     = 6'h0f;
  localparam int BIT_SEL    = 7;
  localparam int BIT_STOP   = 7;
  localparam int BIT_OUT    = 7;
  localparam int BIT_FREQ_TEST    = 6;
  localparam int BIT_ALARM_FLAG   = 7;
  localparam int BIT_SQ_WAVE      = 6;
  localparam int BIT_ALARM_BACKUP = 5;
  localparam int BIT_HALT   = 6;
  localparam logic [7:0] WD_CLEAR = 8'h00;
  localparam int CLK_MHZ = 100;
  // longest time per setting, rounded down
  localparam int T_MS_00  = 98;
  localparam int T_MS_01  = 200;
  localparam int T_US_1X  = 2000;
  localparam int CYC_00   = T_MS_00 * 1000 * CLK_MHZ;
  localparam int CYC_01   = T_MS_01 * 1000 * CLK_MHZ;
  localparam int CYC_1X   = T_US_1X * CLK_MHZ;
  localparam int CNT_W    = 25;
  typedef enum logic [1:0] {
    PUR_OFF = 2'b00,
    PUR_REC = 2'b01,
    PUR_RUN = 2'b11
  } pur_state_t;
endpackage : pur_pkg

//--- pur_timer.sv
`timescale 1ns/1ps
`default_nettype none
module pur_timer (
  input  wire logic                      mclk,
  input  wire logic                      rstn,
  input  wire logic                      start,
  input  wire logic [pur_pkg::CNT_W-1:0] load,
  output logic                           done
);
  logic [pur_pkg::CNT_W-1:0] cnt_r;
  logic                      run_r;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
      run_r <= 1'b0;
    end else if (start) begin
      cnt_r <= load;
      run_r <= 1'b1;
    end else if (run_r && cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end else begin
      run_r <= 1'b0;
    end
  end
  assign done = run_r && cnt_r == '0;
endmodule : pur_timer
`default_nettype wire

//--- pur_pick.sv
`timescale 1ns/1ps
`default_nettype none
module pur_pick (
  input  wire logic                      sel,
  input  wire logic                      stop,
  input  wire logic [pur_pkg::CNT_W-1:0] len_00,
  input  wire logic [pur_pkg::CNT_W-1:0] len_01,
  input  wire logic [pur_pkg::CNT_W-1:0] len_1x,
  output logic [pur_pkg::CNT_W-1:0]      len
);
  always_comb begin
    if (sel)
      len = len_1x;
    else if (stop)
      len = len_01;
    else
      len = len_00;
  end
endmodule : pur_pick
`default_nettype wire

//--- pur_top.sv
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module pur_top #(
  parameter logic [pur_pkg::CNT_W-1:0] LEN_00 = pur_pkg::CNT_W'(pur_pkg::CYC_00),
  parameter logic [pur_pkg::CNT_W-1:0] LEN_01 = pur_pkg::CNT_W'(pur_pkg::CYC_01),
  parameter logic [pur_pkg::CNT_W-1:0] LEN_1X = pur_pkg::CNT_W'(pur_pkg::CYC_1X)
) (
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       supply_ok,
  input  wire logic       battery_valid,
  input  wire logic       power_fail_in,
  input  wire logic [5:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  output logic            cpu_rst_n_o,
  output logic            cpu_rst_n_oe,
  output logic            power_fail_out_n,
  output logic            deselect
);
  pur_pkg::pur_state_t state_r;
  logic       sup_d_r;
  logic       first_r;
  logic       recovery_len_sel_r;
  logic       osc_stop_r;
  logic       out_level_r;
  logic       halt_update_stamp_r;
  logic       freq_test_en_r;
  logic       alarm_flag_en_r;
  logic       alarm_backup_en_r;
  logic       square_wave_en_r;
  logic       watchdog_steer_r;
  logic [4:0] watchdog_multiplier_r;
  logic [1:0] watchdog_resolution_r;
  logic [6:0] min_sec_r;
  logic [6:0] hour_low_r;
  logic [6:0] ctl_low_r;
  logic [5:0] mon_low_r;
  logic [4:0] alm_low_r;
  logic [7:0] rdata_nxt;
  logic [pur_pkg::CNT_W-1:0] len;
  logic       rise;
  logic       done;
  logic       wr_ok;

  // power-up seen as rising supply_ok
  assign rise  = supply_ok && !sup_d_r;
  // writes blocked outside run: supply settling
  assign wr_ok = wr && state_r == pur_pkg::PUR_RUN;

  pur_pick u_pick (
    .sel    (recovery_len_sel_r),
    .stop   (osc_stop_r),
    .len_00 (LEN_00),
    .len_01 (LEN_01),
    .len_1x (LEN_1X),
    .len    (len)
  );

  pur_timer u_timer (
    .mclk  (mclk),
    .rstn  (rstn),
    .start (rise),
    .load  (len),
    .done  (done)
  );

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn)
      sup_d_r <= 1'b0;
    else
      sup_d_r <= supply_ok;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_r <= pur_pkg::PUR_OFF;
    end else if (!supply_ok) begin
      state_r <= pur_pkg::PUR_OFF;
    end else begin
      unique case (state_r)
        pur_pkg::PUR_OFF: if (rise) state_r <= pur_pkg::PUR_REC;
        pur_pkg::PUR_REC: if (done) state_r <= pur_pkg::PUR_RUN;
        pur_pkg::PUR_RUN: state_r <= pur_pkg::PUR_RUN;
        default:          state_r <= pur_pkg::PUR_OFF;
      endcase
    end
  end

  // first power-up: no battery kept state across the outage
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn)
      first_r <= 1'b1;
    else if (rise)
      first_r <= 1'b0;
  end

  // sticky defaults, then software writes
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      recovery_len_sel_r <= 1'b0;
      osc_stop_r         <= 1'b1;
      out_level_r        <= 1'b1;
    end else if (rise && (first_r || !battery_valid)) begin
      recovery_len_sel_r <= 1'b0;
      osc_stop_r         <= 1'b1;
      out_level_r        <= 1'b1;
    end else if (wr_ok) begin
      // backup power-up keeps these three
      if (addr == pur_pkg::ADDR_CLOCK4)
        recovery_len_sel_r <= wdata[pur_pkg::BIT_SEL];
      if (addr == pur_pkg::ADDR_SECONDS)
        osc_stop_r <= wdata[pur_pkg::BIT_STOP];
      if (addr == pur_pkg::ADDR_CONTROL)
        out_level_r <= wdata[pur_pkg::BIT_OUT];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      halt_update_stamp_r   <= 1'b1;
      freq_test_en_r        <= 1'b0;
      alarm_flag_en_r       <= 1'b0;
      alarm_backup_en_r     <= 1'b0;
      square_wave_en_r      <= 1'b0;
      watchdog_steer_r      <= 1'b0;
      watchdog_multiplier_r <= '0;
      watchdog_resolution_r <= '0;
    end else if (rise) begin
      halt_update_stamp_r <= 1'b1;
      freq_test_en_r      <= 1'b0;
      alarm_flag_en_r     <= 1'b0;
      alarm_backup_en_r   <= 1'b0;
      square_wave_en_r    <= 1'b0;
      {watchdog_steer_r, watchdog_multiplier_r, watchdog_resolution_r} <= pur_pkg::WD_CLEAR;
    end else if (wr_ok) begin
      if (addr == pur_pkg::ADDR_ALARM_HR)
        halt_update_stamp_r <= wdata[pur_pkg::BIT_HALT];
      if (addr == pur_pkg::ADDR_CONTROL)
        freq_test_en_r <= wdata[pur_pkg::BIT_FREQ_TEST];
      if (addr == pur_pkg::ADDR_ALARM_MON) begin
        alarm_flag_en_r   <= wdata[pur_pkg::BIT_ALARM_FLAG];
        square_wave_en_r  <= wdata[pur_pkg::BIT_SQ_WAVE];
        alarm_backup_en_r <= wdata[pur_pkg::BIT_ALARM_BACKUP];
      end
      if (addr == pur_pkg::ADDR_WATCHDOG)
        {watchdog_steer_r, watchdog_multiplier_r, watchdog_resolution_r} <= wdata;
    end
  end

  // remaining bits keep no defaults
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      min_sec_r  <= '0;
      hour_low_r <= '0;
      ctl_low_r  <= '0;
      mon_low_r  <= '0;
      alm_low_r  <= '0;
    end else if (wr_ok) begin
      if (addr == pur_pkg::ADDR_SECONDS)   min_sec_r  <= wdata[6:0];
      if (addr == pur_pkg::ADDR_CLOCK4)    hour_low_r <= wdata[6:0];
      if (addr == pur_pkg::ADDR_CONTROL)   ctl_low_r  <= {1'b0, wdata[5:0]};
      if (addr == pur_pkg::ADDR_ALARM_MON) mon_low_r  <= {1'b0, wdata[4:0]};
      if (addr == pur_pkg::ADDR_ALARM_HR)  alm_low_r  <= wdata[4:0];
    end
  end

  always_comb begin
    rdata_nxt = 8'h00;
    unique case (addr)
      pur_pkg::ADDR_SECONDS:   rdata_nxt = {osc_stop_r, min_sec_r};
      pur_pkg::ADDR_CLOCK4:    rdata_nxt = {recovery_len_sel_r, hour_low_r};
      pur_pkg::ADDR_CONTROL:   rdata_nxt = {out_level_r, freq_test_en_r, ctl_low_r[5:0]};
      pur_pkg::ADDR_WATCHDOG:  rdata_nxt = {watchdog_steer_r, watchdog_multiplier_r, watchdog_resolution_r};
      pur_pkg::ADDR_ALARM_MON: rdata_nxt = {alarm_flag_en_r, square_wave_en_r, alarm_backup_en_r, mon_low_r[4:0]};
      pur_pkg::ADDR_ALARM_HR:  rdata_nxt = {1'b0, halt_update_stamp_r, 1'b0, alm_low_r};
      pur_pkg::ADDR_FLAGS:     rdata_nxt = {7'h00, state_r == pur_pkg::PUR_RUN};
      default:                 rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn)
      rdata <= 8'h00;
    else if (rd)
      rdata <= rdata_nxt;
    else
      rdata <= 8'h00;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cpu_rst_n_o      <= 1'b0;
      cpu_rst_n_oe     <= 1'b1;
      power_fail_out_n <= 1'b0;
      deselect         <= 1'b1;
    end else begin
      // open drain: only ever pull low
      cpu_rst_n_o  <= 1'b0;
      cpu_rst_n_oe <= !(supply_ok && state_r == pur_pkg::PUR_RUN);
      deselect     <= !(supply_ok && state_r == pur_pkg::PUR_RUN);
      if (!supply_ok)
        power_fail_out_n <= 1'b0;
      else if (state_r != pur_pkg::PUR_RUN)
        power_fail_out_n <= 1'b1;
      else
        power_fail_out_n <= power_fail_in;
    end
  end
endmodule : pur_top
`default_nettype wire

//--- pur_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module pur_chk #(
  parameter logic [pur_pkg::CNT_W-1:0] LEN_00 = 25'h14,
  parameter logic [pur_pkg::CNT_W-1:0] LEN_01 = 25'h28,
  parameter logic [pur_pkg::CNT_W-1:0] LEN_1X = 25'h05
) (
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic       supply_ok,
  input wire logic       power_fail_in,
  input wire logic       cpu_rst_n_o,
  input wire logic       cpu_rst_n_oe,
  input wire logic       power_fail_out_n,
  input wire logic       deselect
);
  // slack covers the load and state hand-off cycles
  localparam int LMAX = int'(LEN_00 > LEN_01 ? LEN_00 : LEN_01) + 8;
  logic [pur_pkg::CNT_W-1:0] dcnt_r;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) dcnt_r <= '0;
    else if (!supply_ok || !deselect) dcnt_r <= '0;
    else dcnt_r <= dcnt_r + 1'b1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  rst_pin_low_a: assert property (cpu_rst_n_o == 1'b0)
    else $error("reset pin driven high");
  fail_hold_a: assert property (!supply_ok [*2] |=> cpu_rst_n_oe && deselect)
    else $error("no hold-off on supply loss");
  release_pair_a: assert property ($fell(deselect) |-> $fell(cpu_rst_n_oe))
    else $error("reset and deselect released apart");
  rec_floor_a: assert property ($rose(supply_ok) |=> deselect [*5])
    else $error("deselect dropped early");
  rec_min_a: assert property ($fell(deselect) |-> dcnt_r >= LEN_1X)
    else $error("recovery too short");
  rec_max_a: assert property (dcnt_r <= LMAX)
    else $error("recovery too long");
  pf_forced_a: assert property (supply_ok [*3] ##0 deselect |-> power_fail_out_n)
    else $error("power fail out not forced high");
  pf_follow_a: assert property (!deselect && !$past(deselect) |-> power_fail_out_n == $past(power_fail_in))
    else $error("power fail out not following input");
endmodule : pur_chk
bind pur_top pur_chk #(.LEN_00(LEN_00), .LEN_01(LEN_01), .LEN_1X(LEN_1X)) chk_u (
  .mclk(mclk), .rstn(rstn), .supply_ok(supply_ok), .power_fail_in(power_fail_in),
  .cpu_rst_n_o(cpu_rst_n_o), .cpu_rst_n_oe(cpu_rst_n_oe),
  .power_fail_out_n(power_fail_out_n), .deselect(deselect));
`default_nettype wire

//--- pur_host.sv
`timescale 1ns/1ps
`default_nettype none
module pur_host (
  input  wire logic cpu_rst_n_o,
  input  wire logic cpu_rst_n_oe,
  output logic      host_rst_n,
  output logic      host_ok
);
  // pull-up holds the wire high when undriven
  assign host_rst_n = cpu_rst_n_oe ? cpu_rst_n_o : 1'b1;
  assign host_ok = host_rst_n;
endmodule : pur_host
`default_nettype wire

//--- power_up_recovery_defaults_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module power_up_recovery_defaults_tb_top;
  logic       mclk = 1'b0;
  logic       rstn = 1'b0;
  logic       supply_ok = 1'b0;
  logic       battery_valid = 1'b0;
  logic       power_fail_in = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic       rst_o, rst_oe, pf_out_n, deselect, host_rst_n, host_ok;
  int         miscompares = 0;
  int         checked = 0;
  always #5 mclk = ~mclk;
  pur_top #(.LEN_00(25'h14), .LEN_01(25'h28), .LEN_1X(25'h05)) dut_u (
    .mclk(mclk), .rstn(rstn), .supply_ok(supply_ok), .battery_valid(battery_valid),
    .power_fail_in(power_fail_in), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .cpu_rst_n_o(rst_o), .cpu_rst_n_oe(rst_oe),
    .power_fail_out_n(pf_out_n), .deselect(deselect));
  pur_host host_u (.cpu_rst_n_o(rst_o), .cpu_rst_n_oe(rst_oe), .host_rst_n(host_rst_n), .host_ok(host_ok));
  task automatic results;
    $display("miscompares=%0d checked=%0d", miscompares, checked);
    if (miscompares == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results
  task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] got);
    checked++;
    if (got !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, got);
    end
  endtask : cmp
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] m, input logic [7:0] e, input string what);
    @(posedge mclk);
    rd <= 1'b1; addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 cmp(what, e & m, rdata & m);
  endtask : rd_chk
  // bound loop; a hang ends the run
  task automatic power_up(input int len);
    int n;
    n = 0;
    @(posedge mclk);
    supply_ok <= 1'b1;
    do begin
      @(posedge mclk);
      #1 n++;
      if (n == 2) begin
        cmp("host held", {7'h00, host_ok}, 8'h00);
        cmp("fail out forced", {7'h00, pf_out_n}, 8'h01);
      end
    end while (deselect !== 1'b0 && n < 5000);
    cmp("interval", 8'h01, 8'(n >= len && n <= len + 6));
    cmp("host released", {7'h00, host_ok}, 8'h01);
    if (n >= 5000) results();
  endtask : power_up
  task automatic power_down;
    @(posedge mclk);
    supply_ok <= 1'b0;
    repeat (3) @(posedge mclk);
    #1 cmp("host off", {7'h00, host_ok}, 8'h00);
    cmp("fail out low", {7'h00, pf_out_n}, 8'h00);
    @(posedge mclk);
  endtask : power_down
  initial begin
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    repeat (2) @(posedge mclk);
    wr_reg(6'h01, 8'h7f);
    power_up(40);
    rd_chk(6'h04, 8'h80, 8'h00, "sel");
    rd_chk(6'h01, 8'hff, 8'h80, "stop");
    rd_chk(6'h08, 8'hc0, 8'h80, "out freq");
    rd_chk(6'h09, 8'hff, 8'h00, "watchdog");
    rd_chk(6'h0a, 8'he0, 8'h00, "enables");
    rd_chk(6'h0c, 8'h40, 8'h40, "halt");
    rd_chk(6'h0f, 8'h01, 8'h01, "running");
    @(posedge mclk);
    power_fail_in <= 1'b1;
    repeat (3) @(posedge mclk);
    #1 cmp("fail out follow", {7'h00, pf_out_n}, 8'h01);
    wr_reg(6'h04, 8'h80);
    wr_reg(6'h01, 8'h00);
    wr_reg(6'h08, 8'h40);
    wr_reg(6'h09, 8'hff);
    wr_reg(6'h0a, 8'he0);
    wr_reg(6'h0c, 8'h00);
    rd_chk(6'h04, 8'h80, 8'h80, "sel set");
    rd_chk(6'h09, 8'hff, 8'hff, "wd set");
    power_down();
    battery_valid <= 1'b1;
    power_up(5);
    rd_chk(6'h04, 8'h80, 8'h80, "sel kept");
    rd_chk(6'h01, 8'h80, 8'h00, "stop kept");
    rd_chk(6'h08, 8'hc0, 8'h00, "out kept");
    rd_chk(6'h09, 8'hff, 8'h00, "wd clear");
    rd_chk(6'h0a, 8'he0, 8'h00, "en clear");
    rd_chk(6'h0c, 8'h40, 8'h40, "halt set");
    wr_reg(6'h04, 8'h00);
    power_down();
    power_up(20);
    power_down();
    battery_valid <= 1'b0;
    power_up(20);
    rd_chk(6'h01, 8'h80, 8'h80, "stop first");
    rd_chk(6'h08, 8'h80, 8'h80, "out first");
    results();
  end
endmodule : power_up_recovery_defaults_tb_top
`default_nettype wire
